// ==== pgs_regs.vh ====
// pgs_regs.vh: constants for the power-good strap and test mode entry block.
// assumes inclusion by bare name from plain Verilog-2005 design files.
`ifndef PGS_REGS_VH
`define PGS_REGS_VH

// strap status byte: the same layout as the configuration byte at D4h of the bridge function
`define PGS_CFG_OFFSET      8'hd4
`define PGS_NO_REBOOT_BIT   1
`define PGS_SAFE_MODE_BIT   2

// strap setup time, counted in bus clocks
`define PGS_STRAP_SETUP_CLK 4

// low-time counts for test mode decoding
`define PGS_TM_NAND1_CNT    5'h04
`define PGS_TM_NAND4_CNT    5'h07
`define PGS_TM_ALLZ_CNT     5'h08
`define PGS_TM_RSV_LO_CNT   5'h0a
`define PGS_TM_RSV_HI_CNT   5'h18
`define PGS_TM_CNT_MAX      5'h1f

// test mode encodings
`define PGS_TM_NONE         3'h0
`define PGS_TM_NAND1        3'h1
`define PGS_TM_NAND2        3'h2
`define PGS_TM_NAND3        3'h3
`define PGS_TM_NAND4        3'h4
`define PGS_TM_ALLZ         3'h5

// system power states
`define PGS_ST_S0           3'h0
`define PGS_ST_S1           3'h1
`define PGS_ST_S3           3'h3
`define PGS_ST_S4           3'h4
`define PGS_ST_S5           3'h5
`define PGS_ST_G3           3'h7

`endif

// ==== pgs_sync2.v ====
// pgs_sync2.v: two-flop synchroniser for a single pin level.
// assumes the pin is asynchronous to clk; reset level is a parameter.
`timescale 1ns/1ps
module pgs_sync2
#(
   parameter RST_VAL = 1'b0
)
(
   // clock and reset
   input  wire clk,
   input  wire rst_n,
   // level in and out
   input  wire din,
   output wire dout
);

   reg meta_r;
   reg sync_r;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end
      else
      begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end

   assign dout = sync_r;

endmodule // pgs_sync2

// ==== pgs_strap_top.v ====
// pgs_strap_top.v: strap capture at power-good rise, test mode entry by the
// length of a low pulse on rtc reset, and power-plane pin state control.
// assumes MCLK is the 33 MHz bus clock domain; all pins are asynchronous.
//
// Summary of operation
// - capture each strap once at power-good rise, then release pins to normal use
// - speaker strap captured low disables watchdog reboot; weak pull-up
// - reboot-inhibit strap readable as bit 1 of config byte D4h
// - codec serial-out captured high drives processor speed straps to safe mode
// - safe-speed strap readable as bit 2 of config byte D4h
// - while power good high, count clocks with rtc reset low; the count holds between pulses and clears only when power good drops or rises
// - count 4-7 nand chains 1-4, 8 all-z, else no test mode
// - core and hub plane outputs undriven in S3, S4, S5 and G3
// - resume plane outputs keep states through S3-S5, undriven in G3
// - all outputs identical in S4 and S5
// - high-impedance listed pin has its driver disabled
// - undefined listed pin is driven, its value not guaranteed
// - running listed pin keeps toggling
`timescale 1ns/1ps
`include "pgs_regs.vh"
module pgs_strap_top
(
   // clock and reset
   input  wire       MCLK,
   input  wire       NRST,
   // power good, rtc reset and bus reset pins
   input  wire       POWER_GOOD,
   input  wire       RTC_RESET_N,
   input  wire       BUS_RESET_OUT_N,
   // strap pins, input side
   input  wire       SPEAKER_STRAP_PIN_I,
   input  wire       CODEC_SERIAL_OUT_I,
   // strap pins, functional output side
   input  wire       SPEAKER_DATA,
   input  wire       CODEC_SERIAL_DATA,
   output wire       SPEAKER_STRAP_PIN_O,
   output wire       SPEAKER_STRAP_PIN_OE,
   output wire       CODEC_SERIAL_OUT_O,
   output wire       CODEC_SERIAL_OUT_OE,
   output wire       SPEAKER_PULLUP_EN,
   output wire       CODEC_PULLDOWN_EN,
   // captured strap results
   output wire [7:0] STRAP_CFG_BYTE,
   output wire       WATCHDOG_REBOOT_EN,
   output wire       SAFE_SPEED_SEL,
   output wire       STRAPS_VALID,
   // test mode
   output wire [2:0] TEST_MODE,
   output wire       TEST_MODE_LOCKED,
   // power state and plane output enables
   input  wire [2:0] SLEEP_STATE,
   input  wire       CORE_DRIVE_REQ,
   input  wire       RESUME_DRIVE_REQ,
   output wire       CORE_PLANE_OE,
   output wire       HUB_PLANE_OE,
   output wire       RESUME_PLANE_OE,
   // running clock output on the resume plane
   output wire       SUSPEND_CLK_OUT
);

   // test mode decode from the low-time count
   function [2:0] pgs_decode;
      input [4:0] cnt;
      begin
         if (cnt >= `PGS_TM_NAND1_CNT && cnt <= `PGS_TM_NAND4_CNT)
            pgs_decode = cnt[2:0] - 3'h3;
         else if (cnt == `PGS_TM_ALLZ_CNT)
            pgs_decode = `PGS_TM_ALLZ;
         else
            pgs_decode = `PGS_TM_NONE;
      end
   endfunction

   // a plane is powered unless the state removes main (or standby) power
   function main_on;
      input [2:0] st;
      begin
         main_on = (st == `PGS_ST_S0) || (st == `PGS_ST_S1);
      end
   endfunction

   wire       pg_s;
   wire       rtc_n_s;
   wire       bus_rst_n_s;
   wire       speaker_strap_pin_s;
   wire       codec_s;

   pgs_sync2 #(.RST_VAL(1'b0)) u_sync_pg
   (
      .clk  (MCLK),
      .rst_n(NRST),
      .din  (POWER_GOOD),
      .dout (pg_s)
   );

   pgs_sync2 #(.RST_VAL(1'b1)) u_sync_rtc
   (
      .clk  (MCLK),
      .rst_n(NRST),
      .din  (RTC_RESET_N),
      .dout (rtc_n_s)
   );

   pgs_sync2 #(.RST_VAL(1'b0)) u_sync_brst
   (
      .clk  (MCLK),
      .rst_n(NRST),
      .din  (BUS_RESET_OUT_N),
      .dout (bus_rst_n_s)
   );

   // straps see the same two-flop delay as power good so the capture
   // looks at levels that were stable before the rise
   pgs_sync2 #(.RST_VAL(1'b1)) u_sync_speaker_strap_pin
   (
      .clk  (MCLK),
      .rst_n(NRST),
      .din  (SPEAKER_STRAP_PIN_I),
      .dout (speaker_strap_pin_s)
   );

   pgs_sync2 #(.RST_VAL(1'b0)) u_sync_codec
   (
      .clk  (MCLK),
      .rst_n(NRST),
      .din  (CODEC_SERIAL_OUT_I),
      .dout (codec_s)
   );

   reg        pg_d_r;
   reg        no_reboot_r;
   reg        safe_mode_r;
   reg        valid_r;
   reg [4:0]  low_cnt_r;
   reg [4:0]  low_cnt_nxt;
   reg        rtc_d_r;
   reg [2:0]  tmode_r;
   reg        locked_r;
   reg        sus_clk_r;

   wire pg_rise = pg_s & ~pg_d_r;
   wire rtc_rise = rtc_n_s & ~rtc_d_r;

   // strap capture, one shot per power-good rise
   always @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         pg_d_r      <= 1'b0;
         no_reboot_r <= 1'b0;
         safe_mode_r <= 1'b0;
         valid_r     <= 1'b0;
      end
      else
      begin
         pg_d_r <= pg_s;
         if (pg_rise)
         begin
            no_reboot_r <= ~speaker_strap_pin_s;
            safe_mode_r <= codec_s;
            valid_r     <= 1'b1;
         end
         else if (!pg_s)
            valid_r <= 1'b0;
      end
   end

   // low-time counter saturates so long pulses decode as no test mode
   always @*
   begin
      low_cnt_nxt = low_cnt_r;
      if (!pg_s || pg_rise)
         low_cnt_nxt = 5'h00;
      else if (!rtc_n_s && low_cnt_r != `PGS_TM_CNT_MAX)
         low_cnt_nxt = low_cnt_r + 5'h01;
   end

   always @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         low_cnt_r <= 5'h00;
         rtc_d_r   <= 1'b1;
         tmode_r   <= `PGS_TM_NONE;
         locked_r  <= 1'b0;
      end
      else
      begin
         rtc_d_r   <= rtc_n_s;
         low_cnt_r <= low_cnt_nxt;
         if (!pg_s || pg_rise)
         begin
            tmode_r  <= `PGS_TM_NONE;
            locked_r <= 1'b0;
         end
         else if (rtc_rise && !locked_r && low_cnt_r != 5'h00)
         begin
            // reserved counts 10..24 are the board's to avoid; they decode as none
            tmode_r  <= pgs_decode(low_cnt_r);
            locked_r <= 1'b1;
         end
      end
   end

   // free-running divided clock, stands for the resume plane running pin
   always @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
         sus_clk_r <= 1'b0;
      else
         sus_clk_r <= ~sus_clk_r;
   end

   wire main_pwr   = main_on(SLEEP_STATE);
   wire resume_pwr = (SLEEP_STATE != `PGS_ST_G3);
   wire all_z      = (tmode_r == `PGS_TM_ALLZ);

   // S4 and S5 both fall outside main_on, so they share one set of levels
   assign CORE_PLANE_OE   = main_pwr & CORE_DRIVE_REQ & ~all_z;
   assign HUB_PLANE_OE    = main_pwr & ~all_z;
   assign RESUME_PLANE_OE = resume_pwr & RESUME_DRIVE_REQ & ~all_z;
   assign SUSPEND_CLK_OUT = resume_pwr & sus_clk_r;

   // straps are only inputs until captured; afterwards the pins get their
   // functions back, gated by bus reset so the speaker stays tri-stated in reset
   wire pins_free = valid_r & bus_rst_n_s & main_pwr & ~all_z;
   assign SPEAKER_STRAP_PIN_O  = SPEAKER_DATA;
   assign SPEAKER_STRAP_PIN_OE = pins_free;
   // codec data may be undefined right after reset; driver shares the speaker's pins_free gate, bus reset included
   assign CODEC_SERIAL_OUT_O   = CODEC_SERIAL_DATA;
   assign CODEC_SERIAL_OUT_OE  = pins_free;
   assign SPEAKER_PULLUP_EN    = ~valid_r;
   assign CODEC_PULLDOWN_EN    = ~valid_r;

   assign STRAP_CFG_BYTE     = {5'h00, safe_mode_r, no_reboot_r, 1'b0};
   assign WATCHDOG_REBOOT_EN = ~no_reboot_r;
   assign SAFE_SPEED_SEL     = safe_mode_r;
   assign STRAPS_VALID       = valid_r;
   assign TEST_MODE          = tmode_r;
   assign TEST_MODE_LOCKED   = locked_r;

endmodule // pgs_strap_top

// ==== pgs_strap_top_assertions.sv ====
// checker: strap capture, test mode latch, plane enables
// assumes bind onto pgs_strap_top, one clock domain
`timescale 1ns/1ps
module pgs_chk
(
   // watched ports
   input wire       MCLK,
   input wire       NRST,
   input wire       RTC_RESET_N,
   input wire [2:0] SLEEP_STATE,
   input wire       SPEAKER_PULLUP_EN,
   input wire [7:0] STRAP_CFG_BYTE,
   input wire       STRAPS_VALID,
   input wire [2:0] TEST_MODE,
   input wire       TEST_MODE_LOCKED,
   input wire       CORE_PLANE_OE,
   input wire       HUB_PLANE_OE,
   input wire       RESUME_PLANE_OE,
   input wire       SUSPEND_CLK_OUT
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   chk_pull_off: assert property
      (STRAPS_VALID |-> !SPEAKER_PULLUP_EN) else $error("pull on");
   chk_cfg_hold: assert property
      (STRAPS_VALID && $past(STRAPS_VALID) |-> $stable(STRAP_CFG_BYTE)) else $error("cfg moved");
   chk_core_off: assert property
      (SLEEP_STATE > 3'h1 |-> !CORE_PLANE_OE && !HUB_PLANE_OE) else $error("core on");
   chk_resume_g3: assert property
      (SLEEP_STATE == 3'h7 |-> !RESUME_PLANE_OE) else $error("resume on");
   chk_allz_float: assert property
      (TEST_MODE == 3'h5 |-> !(CORE_PLANE_OE | RESUME_PLANE_OE)) else $error("not float");
   chk_clk_runs: assert property
      ((SLEEP_STATE != 3'h7) [*3] |-> SUSPEND_CLK_OUT != $past(SUSPEND_CLK_OUT))
      else $error("clk stuck");
   chk_tm_latch: assert property
      ($rose(RTC_RESET_N) && STRAPS_VALID |-> ##[1:4] TEST_MODE_LOCKED) else $error("no lock");
   chk_tm_hold: assert property
      (TEST_MODE_LOCKED && $past(TEST_MODE_LOCKED) |-> $stable(TEST_MODE)) else $error("mode moved");
   cover property ($rose(STRAPS_VALID));
   cover property ($rose(TEST_MODE_LOCKED) && TEST_MODE == 3'h5);
   cover property (SLEEP_STATE == 3'h7);
endmodule // pgs_chk

bind pgs_strap_top pgs_chk u_chk (.MCLK, .NRST, .RTC_RESET_N, .SLEEP_STATE,
   .SPEAKER_PULLUP_EN, .STRAP_CFG_BYTE, .STRAPS_VALID, .TEST_MODE, .TEST_MODE_LOCKED,
   .CORE_PLANE_OE, .HUB_PLANE_OE, .RESUME_PLANE_OE, .SUSPEND_CLK_OUT);

// ==== pgs_board.sv ====
// board model: power good, rtc reset, bus reset and strap levels
// assumes the bench calls run once per power-up
`timescale 1ns/1ps
module pgs_board
(
   // board pins
   input  wire clk,
   output reg  pg = 1'b0,
   output reg  rtc_n = 1'b1,
   output reg  brst_n = 1'b0,
   output reg  spk = 1'b1,
   output reg  cod = 1'b0
);
   task run(input logic s, input logic c, input int n);
      @(posedge clk);
      #2 pg = 1'b0;
      brst_n = 1'b0;
      spk = s;
      cod = c;
      repeat (7) @(posedge clk);
      #2 brst_n = 1'b1;
      @(posedge clk);
      #2 pg = 1'b1;
      repeat (3) @(posedge clk);
      if (n > 0 && (n < 10 || n > 24))
      begin
         #2 rtc_n = 1'b0;
         repeat (n) @(posedge clk);
         #2 rtc_n = 1'b1;
      end
      repeat (4) @(posedge clk);
      // flipped, not held: a stale level would hide a late capture
      #2 spk = ~s;
      cod = ~c;
   endtask
   // extra low pulse after a selection is latched; callers keep n out of 10..24
   task pulse(input int n);
      @(posedge clk);
      #2 rtc_n = 1'b0;
      repeat (n) @(posedge clk);
      #2 rtc_n = 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule // pgs_board

// ==== tb.sv ====
// bench for the strap and test mode block
// assumes pgs_board drives the pins; 100 ns clock
`timescale 1ns/1ps
module tb;
   reg        mclk = 1'b0;
   reg        nrst = 1'b0;
   reg  [2:0] st = 3'h0;
   wire       pg, rtc_n, brst_n, spk, cod, spk_o, spk_oe, cod_o, cod_oe;
   wire       wd_en, safe, valid, lck, core_oe, hub_oe, res_oe, pu, pd, sclk;
   wire [7:0] cfg;
   wire [2:0] tm;
   int        bad_count = 0;
   int        samples_checked = 0;
   always #50 mclk = ~mclk;
   pgs_board brd (.clk(mclk), .pg, .rtc_n, .brst_n, .spk, .cod);
   pgs_strap_top uut (.MCLK(mclk), .NRST(nrst), .POWER_GOOD(pg), .RTC_RESET_N(rtc_n),
      .BUS_RESET_OUT_N(brst_n), .SPEAKER_STRAP_PIN_I(spk_oe ? spk_o : spk),
      .CODEC_SERIAL_OUT_I(cod_oe ? cod_o : cod), .SPEAKER_DATA(1'b1),
      .CODEC_SERIAL_DATA(1'b0), .SPEAKER_STRAP_PIN_O(spk_o), .SPEAKER_STRAP_PIN_OE(spk_oe),
      .CODEC_SERIAL_OUT_O(cod_o), .CODEC_SERIAL_OUT_OE(cod_oe), .SPEAKER_PULLUP_EN(pu),
      .CODEC_PULLDOWN_EN(pd), .STRAP_CFG_BYTE(cfg), .WATCHDOG_REBOOT_EN(wd_en),
      .SAFE_SPEED_SEL(safe), .STRAPS_VALID(valid), .TEST_MODE(tm), .TEST_MODE_LOCKED(lck),
      .SLEEP_STATE(st), .CORE_DRIVE_REQ(1'b1), .RESUME_DRIVE_REQ(1'b1),
      .CORE_PLANE_OE(core_oe), .HUB_PLANE_OE(hub_oe), .RESUME_PLANE_OE(res_oe),
      .SUSPEND_CLK_OUT(sclk));

   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task t_straps(input logic s, input logic c);
      brd.run(s, c, 0);
      for (int k = 0; k < 9 && valid !== 1'b1; k++) @(posedge mclk);
      repeat (4) @(posedge mclk);
      #2 chk("valid", valid, 1'b1);
      chk("cfg", cfg, {5'h0, c, ~s, 1'b0});
      chk("reboot", wd_en, s);
      chk("safe", safe, c);
      chk("pulls", {pu, pd}, 8'h00);
      chk("pin_oe", {spk_oe, cod_oe}, 8'h03);
      $display("straps %b %b done", s, c);
   endtask

   task automatic t_modes;
      int ns[10] = '{0, 3, 4, 5, 6, 7, 8, 9, 25, 26};
      int e;
      foreach (ns[i])
      begin
         brd.run(1'b1, 1'b0, ns[i]);
         e = (ns[i] == 8) ? 5 : (ns[i] > 3 && ns[i] < 8) ? ns[i] - 3 : 0;
         for (int k = 0; k < 9 && lck !== 1'b1; k++) @(posedge mclk);
         #2 chk("mode", {5'h0, tm}, e[7:0]);
         chk("lock", lck, ns[i] > 0);
         if (ns[i] == 8)
            chk("float", {core_oe, res_oe, spk_oe, cod_oe}, 8'h00);
      end
      // a second pulse after the latch must leave the selection alone
      brd.run(1'b1, 1'b0, 6);
      brd.pulse(8);
      #2 chk("relock", {5'h0, tm}, 8'h03);
      $display("test modes done");
   endtask

   task automatic t_planes;
      logic [2:0] sts[6] = '{0, 1, 3, 4, 5, 7};
      logic [2:0] s4;
      logic       sv;
      logic       ex;
      foreach (sts[i])
      begin
         @(posedge mclk);
         #2 st = sts[i];
         @(posedge mclk);
         #2 chk("core", {core_oe, hub_oe}, {2{sts[i] < 3'h2}});
         chk("resume", res_oe, sts[i] != 3'h7);
         if (sts[i] == 3'h4)
            s4 = {core_oe, hub_oe, res_oe};
         if (sts[i] == 3'h5)
            chk("s4s5", {core_oe, hub_oe, res_oe}, s4);
         // one-bit expectation: inverting inside the wider argument would set upper bits
         sv = sclk;
         ex = (sts[i] != 3'h7) ? ~sv : 1'b0;
         @(posedge mclk);
         #2 chk("sclk", sclk, ex);
      end
      $display("planes done");
   endtask

   // limit is some fifty times the expected run
   initial
   begin
      #2000000;
      bad_count++;
      print_verdict;
   end

   initial
   begin
      repeat (16) @(posedge mclk);
      #2 nrst = 1'b1;
      t_straps(1'b0, 1'b1);
      t_straps(1'b1, 1'b0);
      t_modes;
      t_planes;
      print_verdict;
   end
endmodule // tb
